// >>> afe_regbank.v
// Serial-port register bank holding the front-end control and clock configuration
`timescale 1ns/1ns
`include "afe_regbank_map.vh"

module afe_regbank (
  // Clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // Serial port pins
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        mosi,
  output wire        miso_o,
  output wire        miso_oe,
  // Status flag handling
  input  wire        checksum_error_clear,
  output reg         checksum_error_flag,
  // Checksum and clock mode
  output wire        crc_active,
  output reg         ext_clock_select,
  // Resistive-sensor currents
  output reg         rtd_current_kill,
  output reg         rtd_currents_on,
  // Open-wire detection currents, negative input
  output wire        neg_input_sink_large,
  output wire        neg_input_sink_small,
  output wire        neg_input_source_large,
  output wire        neg_input_source_small,
  // Open-wire detection currents, positive input
  output wire        pos_input_sink_large,
  output wire        pos_input_sink_small,
  output wire        pos_input_source_large,
  output wire        pos_input_source_small,
  // Analog configuration
  output wire [1:0]  common_mode_bias_field,
  output reg         bias_on,
  output wire        field_supply_enable,
  output wire        sense_resistor_select,
  output wire        current_input_select
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CMD  = 5'b00010;
  localparam [4:0] ST_DATA = 5'b00100;
  localparam [4:0] ST_CRC  = 5'b01000;
  localparam [4:0] ST_DONE = 5'b10000;

  // One serial CRC step, polynomial x^8+x^2+x+1
  function [7:0] crc_bit;
    input [7:0] crc;
    input       din;
    reg         fb;
    begin
      fb      = crc[7] ^ din;
      crc_bit = {crc[6:0], 1'b0} ^ (fb ? `AFE_CRC_POLY : 8'h00);
    end
  endfunction

  // Pin synchronisers; stage one feeds only stage two
  reg [2:0]  sclk_sync_reg;
  reg [1:0]  cs_sync_reg;
  reg [1:0]  mosi_sync_reg;

  // Register contents
  reg [15:0] ctrl_one_reg;
  reg [15:0] clk_cfg_reg;
  reg [15:0] ctrl_two_reg;

  // Frame state
  reg [4:0]  state_reg;
  reg [5:0]  bit_cnt_reg;
  reg [7:0]  cmd_reg;
  reg [15:0] rx_reg;
  reg [23:0] tx_reg;
  reg        miso_reg;
  reg [7:0]  crc_reg;
  reg [7:0]  crc_exp_reg;

  wire       sclk_rise  = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire       sclk_fall  = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire       cs_active  = ~cs_sync_reg[1];
  wire       mosi_s     = mosi_sync_reg[1];
  wire       is_read    = cmd_reg[`AFE_CMD_READ_BIT];
  wire [5:0] addr       = cmd_reg[5:0];
  wire [5:0] cnt_inc    = bit_cnt_reg + 6'd1;
  wire       line_bit   = (state_reg == ST_CMD || !is_read) ? mosi_s : miso_reg;
  wire [7:0] crc_next   = crc_bit(crc_reg, line_bit);
  wire [15:0] wr_data   = {rx_reg[14:0], mosi_s};

  // Checksum mode decode
  // CRC on only for 10
  assign crc_active = (ctrl_one_reg[`AFE_CRC_EN_HI:`AFE_CRC_EN_LO] == `AFE_CRC_ON_CODE);

  // One-hot register select; unmapped addresses select nothing
  function [2:0] reg_select;
    input [5:0] a;
    begin
      case (a)
        `AFE_ADDR_CTRL_ONE: reg_select = 3'b001;
        `AFE_ADDR_CLK_CFG:  reg_select = 3'b010;
        `AFE_ADDR_CTRL_TWO: reg_select = 3'b100;
        default:            reg_select = 3'b000;
      endcase
    end
  endfunction

  // Write commit: end of data without CRC, or end of CRC with a match
  wire       at_data_end = sclk_rise && state_reg == ST_DATA && cnt_inc == `AFE_DATA_END;
  wire       at_crc_end  = sclk_rise && state_reg == ST_CRC && cnt_inc == `AFE_CRC_END;
  wire       crc_match   = ({rx_reg[6:0], mosi_s} == crc_exp_reg);
  wire       wr_commit   = !is_read && ((at_data_end && !crc_active) ||
                                        (at_crc_end && crc_match));
  // A failed checksum drops the write and only raises the flag
  wire       crc_fail    = !is_read && at_crc_end && !crc_match;
  wire [2:0] wr_sel      = reg_select(addr);
  reg [15:0] commit_data_reg;
  wire [15:0] commit_data = crc_active ? commit_data_reg : wr_data;

  // Reset levels match the idle pins, so no false edge follows reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_sync_reg <= 3'b111;
      cs_sync_reg   <= 2'b11;
      mosi_sync_reg <= 2'b00;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
    end
  end

  // Frame sequencer
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= ST_IDLE;
      bit_cnt_reg     <= 6'd0;
      cmd_reg         <= 8'h00;
      rx_reg          <= 16'h0000;
      tx_reg          <= 24'h000000;
      miso_reg        <= 1'b0;
      crc_reg         <= 8'h00;
      crc_exp_reg     <= 8'h00;
      commit_data_reg <= 16'h0000;
    end else if (!cs_active) begin
      // Chip select rising mid-frame abandons it with no write
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 6'd0;
      crc_reg     <= 8'h00;
      miso_reg    <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg   <= ST_CMD;
          bit_cnt_reg <= 6'd0;
          crc_reg     <= 8'h00;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            bit_cnt_reg <= cnt_inc;
            crc_reg     <= crc_next;
            if (cnt_inc == `AFE_CMD_BITS) begin
              cmd_reg   <= {cmd_reg[6:0], mosi_s};
              state_reg <= ST_DATA;
            end else begin
              cmd_reg <= {cmd_reg[6:0], mosi_s};
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            bit_cnt_reg <= cnt_inc;
            crc_reg     <= crc_next;
            rx_reg      <= wr_data;
            if (cnt_inc == `AFE_DATA_END) begin
              crc_exp_reg     <= crc_next;
              commit_data_reg <= wr_data;
              tx_reg          <= {crc_next, 16'h0000};
              // Mode sampled here: the write that enables checksums is unchecked
              state_reg       <= crc_active ? ST_CRC : ST_DONE;
            end
          end else if (sclk_fall && is_read) begin
            miso_reg <= tx_reg[23];
            tx_reg   <= {tx_reg[22:0], 1'b0};
          end
        end
        ST_CRC: begin
          if (sclk_rise) begin
            bit_cnt_reg <= cnt_inc;
            rx_reg      <= wr_data;
            if (cnt_inc == `AFE_CRC_END) begin
              state_reg <= ST_DONE;
            end
          end else if (sclk_fall && is_read) begin
            miso_reg <= tx_reg[23];
            tx_reg   <= {tx_reg[22:0], 1'b0};
          end
        end
        ST_DONE: begin
          // Extra bits are ignored until chip select rises
          miso_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // Read data is loaded once the command byte is complete
      if (state_reg == ST_CMD && sclk_rise && cnt_inc == `AFE_CMD_BITS) begin
        tx_reg <= {rd_data_next(cmd_reg, mosi_s), 8'h00};
      end
    end
  end

  // Read data for the address formed by the last command bit
  function [15:0] rd_data_next;
    input [7:0] cmd;
    input       last;
    reg   [2:0] sel;
    begin
      sel          = reg_select({cmd[4:0], last});
      rd_data_next = ({16{sel[0]}} & ctrl_one_reg) |
                     ({16{sel[1]}} & clk_cfg_reg) |
                     ({16{sel[2]}} & ctrl_two_reg);
    end
  endfunction

  // Data line is driven only in the data and checksum phases of a read
  assign miso_o  = miso_reg;
  assign miso_oe = cs_active && is_read &&
                   (state_reg == ST_DATA || state_reg == ST_CRC);

  // Register file
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_one_reg <= `AFE_RST_CTRL_ONE;
      clk_cfg_reg  <= `AFE_RST_CLK_CFG;
      ctrl_two_reg <= `AFE_RST_CTRL_TWO;
    end else if (wr_commit) begin
      if (wr_sel[0]) begin
        ctrl_one_reg <= commit_data & `AFE_MASK_CTRL_ONE;
      end
      if (wr_sel[1]) begin
        clk_cfg_reg <= commit_data & `AFE_MASK_CLK_CFG;
      end
      if (wr_sel[2]) begin
        ctrl_two_reg <= commit_data & `AFE_MASK_CTRL_TWO;
      end
    end
  end

  // Checksum error flag, set wins over clear
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      checksum_error_flag <= 1'b0;
    end else if (crc_fail) begin
      checksum_error_flag <= 1'b1;
    end else if (checksum_error_clear) begin
      checksum_error_flag <= 1'b0;
    end
  end

  // Decoded control outputs
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rtd_current_kill <= 1'b0;
      rtd_currents_on  <= 1'b1;
      ext_clock_select <= 1'b0;
      bias_on          <= 1'b0;
    end else begin
      rtd_current_kill <= ctrl_one_reg[`AFE_RTD_KILL_BIT];
      rtd_currents_on  <= ~ctrl_one_reg[`AFE_RTD_KILL_BIT];
      // Reserved field codes are stored as written and decode as not selected
      // Converter clock on 10
      ext_clock_select <= (clk_cfg_reg[`AFE_CLK_SRC_HI:`AFE_CLK_SRC_LO] == `AFE_CLK_EXT_CODE);
      bias_on          <= (ctrl_two_reg[`AFE_BIAS_HI:`AFE_BIAS_LO] == `AFE_BIAS_ON_CODE);
    end
  end

  assign neg_input_sink_large   = ctrl_two_reg[15];
  assign neg_input_sink_small   = ctrl_two_reg[14];
  assign neg_input_source_large = ctrl_two_reg[13];
  assign neg_input_source_small = ctrl_two_reg[12];
  assign pos_input_sink_large   = ctrl_two_reg[11];
  assign pos_input_sink_small   = ctrl_two_reg[10];
  assign pos_input_source_large = ctrl_two_reg[9];
  assign pos_input_source_small = ctrl_two_reg[8];

  assign common_mode_bias_field = ctrl_two_reg[`AFE_BIAS_HI:`AFE_BIAS_LO];
  assign field_supply_enable    = ctrl_two_reg[`AFE_FIELD_PWR_BIT];
  assign sense_resistor_select  = ctrl_two_reg[`AFE_SENSE_RES_BIT];
  assign current_input_select   = ctrl_two_reg[`AFE_CURRENT_INPUT_SELECT_BIT];

endmodule

// >>> afe_regbank_map.vh
// Offsets, field positions, reset values and framing constants of the front-end register bank
// How it works
// - Checksum field 00 disables CRC, 10 enables 8-bit CRC on reads and writes
// - Kill bit 9 set turns off every excitation and compensation current
// - Clock source field 00 selects internal clock, 10 selects converter clock
// - Bits 15..12 enable negative-input open-wire sink and source currents
// - Bits 11..8 enable positive-input open-wire sink and source currents
// - Bias field 01 enables 50 uA bias, 10 or 11 disable, resets 10
// - Bit 3 switches the field power supply, reset value 0
// - Bit 2 selects external sense resistor when 1, internal when 0
// - Bit 1 selects current input mode when 1, resets to current mode
// - Second control resets to 0x0082, first control and clock config to 0
// - Checksum mismatch on a register write sets the checksum error flag
`ifndef AFE_REGBANK_MAP_VH
`define AFE_REGBANK_MAP_VH

// Register addresses
`define AFE_ADDR_CTRL_ONE   6'h01
`define AFE_ADDR_CLK_CFG    6'h03
`define AFE_ADDR_CTRL_TWO   6'h04

// Writable bit masks
`define AFE_MASK_CTRL_ONE   16'h6200
`define AFE_MASK_CLK_CFG    16'h0018
`define AFE_MASK_CTRL_TWO   16'hffce

// Reset values
`define AFE_RST_CTRL_ONE    16'h0000
`define AFE_RST_CLK_CFG     16'h0000
`define AFE_RST_CTRL_TWO    16'h0082

// Field positions
`define AFE_CRC_EN_HI       14
`define AFE_CRC_EN_LO       13
`define AFE_RTD_KILL_BIT    9
`define AFE_CLK_SRC_HI      4
`define AFE_CLK_SRC_LO      3
`define AFE_BIAS_HI         7
`define AFE_BIAS_LO         6
`define AFE_FIELD_PWR_BIT   3
`define AFE_SENSE_RES_BIT   2
`define AFE_CURRENT_INPUT_SELECT_BIT       1

// Field codes
`define AFE_CRC_ON_CODE     2'b10
`define AFE_CLK_EXT_CODE    2'b10
`define AFE_BIAS_ON_CODE    2'b01

// Frame layout: 8-bit command, 16-bit data, optional 8-bit checksum
`define AFE_CMD_BITS        6'd8
`define AFE_DATA_END        6'd24
`define AFE_CRC_END         6'd32
`define AFE_CMD_READ_BIT    6
`define AFE_CRC_POLY        8'h07

`endif

// >>> afe_regbank_properties.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module afe_regbank_properties (
  // Clock and reset
  input wire       mclk,
  input wire       rstn,
  // Serial port pins
  input wire       cs_n,
  input wire       miso_oe,
  // Flags and decodes
  input wire       checksum_error_clear,
  input wire       checksum_error_flag,
  input wire       crc_active,
  input wire       rtd_current_kill,
  input wire       rtd_currents_on,
  input wire       bias_on,
  // Analog configuration
  input wire [1:0] common_mode_bias_field,
  input wire       field_supply_enable,
  input wire       sense_resistor_select,
  input wire       current_input_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  kill_stops_currents_a: assert property (rtd_current_kill |-> ##[0:1] !rtd_currents_on)
    else $error("currents on while kill set");
  no_kill_currents_a: assert property (!rtd_current_kill |-> ##[0:1] rtd_currents_on)
    else $error("currents off while kill clear");
  bias_decode_a: assert property (##1 bias_on == ($past(common_mode_bias_field) == 2'b01))
    else $error("bias enable does not follow bias field");
  flag_sticky_a: assert property (checksum_error_flag && !checksum_error_clear
    |=> checksum_error_flag)
    else $error("checksum flag lost without clear");
  flag_cause_a: assert property ($rose(checksum_error_flag) |-> crc_active)
    else $error("checksum flag set with checksum off");
  flag_clear_a: assert property (checksum_error_clear && cs_n && $past(cs_n, 8)
    |=> !checksum_error_flag)
    else $error("checksum flag not cleared");
  idle_config_a: assert property (cs_n && $past(cs_n, 6) |->
    $stable({common_mode_bias_field, field_supply_enable, sense_resistor_select,
    current_input_select, crc_active}))
    else $error("configuration moved without a frame");
  idle_release_a: assert property (cs_n [*4] |-> !miso_oe)
    else $error("data line driven while deselected");
endmodule
bind afe_regbank afe_regbank_properties u_props (.mclk(mclk), .rstn(rstn), .cs_n(cs_n),
  .miso_oe(miso_oe), .checksum_error_clear(checksum_error_clear),
  .checksum_error_flag(checksum_error_flag), .crc_active(crc_active),
  .rtd_current_kill(rtd_current_kill), .rtd_currents_on(rtd_currents_on), .bias_on(bias_on),
  .common_mode_bias_field(common_mode_bias_field), .field_supply_enable(field_supply_enable),
  .sense_resistor_select(sense_resistor_select), .current_input_select(current_input_select));

// >>> afe_host_model.sv
// Host serial master model sending mode 3 frames
`timescale 1ns/1ns
module afe_host_model (
  // Clock
  input wire  mclk,
  // Serial port pins
  output reg  sclk,
  output reg  cs_n,
  output reg  mosi,
  input  wire miso_o,
  input  wire miso_oe
);
  reg  miso_last = 1'b0;
  // Released line shows the inverse of its last driven level
  wire miso = miso_oe ? miso_o : ~miso_last;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  always @(posedge mclk) if (miso_oe) miso_last <= miso_o;
  // Shift n bits MSB first, half period 5 mclk, sample on rise
  task frame(input [31:0] tx, input integer n, output [31:0] rx);
    integer i;
    begin
      rx = 32'h0;
      @(posedge mclk) cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      for (i = n - 1; i >= 0; i = i - 1) begin
        sclk <= 1'b0;
        mosi <= tx[i];
        repeat (5) @(posedge mclk);
        rx = {rx[30:0], miso};
        sclk <= 1'b1;
        repeat (5) @(posedge mclk);
      end
      cs_n <= 1'b1;
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule

// >>> tb_afe_regbank.sv
// Self-checking bench for the front-end register bank
`timescale 1ns/1ns
`include "afe_regbank_map.vh"
module tb_afe_regbank;
  reg         mclk = 1'b0;
  reg         rstn = 1'b0;
  reg         checksum_error_clear = 1'b0;
  reg         crc_on = 1'b0;
  reg  [31:0] rx;
  integer     bad_count = 0;
  integer     n_tests = 0;
  integer     k;
  wire        sclk, cs_n, mosi, miso_o, miso_oe, flag, crc_active, ext_clk, kill, on, bias_on;
  wire        fse, srs, cis;
  wire [7:0]  owd;
  wire [1:0]  cmb;
  wire [15:0] cfg = {owd, cmb, 2'b00, fse, srs, cis, 1'b0};
  wire [15:0] stat = {10'h0, crc_active, ext_clk, kill, on, bias_on, flag};
  always #5 mclk = ~mclk;
  afe_host_model host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe));
  afe_regbank dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .checksum_error_clear(checksum_error_clear),
    .checksum_error_flag(flag), .crc_active(crc_active), .ext_clock_select(ext_clk),
    .rtd_current_kill(kill), .rtd_currents_on(on), .neg_input_sink_large(owd[7]),
    .neg_input_sink_small(owd[6]), .neg_input_source_large(owd[5]),
    .neg_input_source_small(owd[4]), .pos_input_sink_large(owd[3]),
    .pos_input_sink_small(owd[2]), .pos_input_source_large(owd[1]),
    .pos_input_source_small(owd[0]), .common_mode_bias_field(cmb), .bias_on(bias_on),
    .field_supply_enable(fse), .sense_resistor_select(srs), .current_input_select(cis));
  task check(input [8*8-1:0] what, input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  function [7:0] crc8(input [23:0] d);
    integer i;
    begin
      crc8 = 8'h00;
      for (i = 23; i >= 0; i = i - 1)
        crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ d[i]) ? `AFE_CRC_POLY : 8'h00);
    end
  endfunction
  task wr(input [5:0] a, input [15:0] d, input [7:0] flip);
    begin
      if (crc_on) host.frame({2'b00, a, d, crc8({2'b00, a, d}) ^ flip}, 32, rx);
      else host.frame({8'h00, 2'b00, a, d}, 24, rx);
    end
  endtask
  task rc(input [5:0] a, input [15:0] e);
    begin
      if (crc_on) begin
        host.frame({2'b01, a, 24'h0}, 32, rx);
        check("rd crc", rx[7:0], crc8({2'b01, a, e}));
        check("rd data", rx[23:8], e);
      end else begin
        host.frame({8'h00, 2'b01, a, 16'h0}, 24, rx);
        check("rd data", rx[15:0], e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    rc(`AFE_ADDR_CTRL_ONE, `AFE_RST_CTRL_ONE);
    rc(`AFE_ADDR_CLK_CFG, `AFE_RST_CLK_CFG);
    rc(`AFE_ADDR_CTRL_TWO, 16'h0082);
    check("outputs", cfg, 16'h0082);
    check("status", stat, 16'h0004);
    wr(`AFE_ADDR_CTRL_TWO, 16'hffff, 8'h00);
    rc(`AFE_ADDR_CTRL_TWO, 16'hffce);
    check("outputs", cfg, 16'hffce);
    wr(`AFE_ADDR_CTRL_TWO, 16'h0040, 8'h00);
    check("outputs", cfg, 16'h0040);
    check("status", stat, 16'h0006 | 16'h0002 << 0);
    for (k = 0; k < 4; k = k + 1) if (k != 2) begin
      wr(`AFE_ADDR_CTRL_ONE, 16'h9e00 | k << 13, 8'h00);
      rc(`AFE_ADDR_CTRL_ONE, 16'h0200 | k << 13);
      check("status", stat, 16'h000a);
      wr(`AFE_ADDR_CLK_CFG, 16'hffe7 | k << 3, 8'h00);
      rc(`AFE_ADDR_CLK_CFG, k << 3);
      check("ext clk", ext_clk, 16'h0);
    end
    // Host initialisation selects the converter clock
    wr(`AFE_ADDR_CLK_CFG, 16'h0010, 8'h00);
    check("ext clk", ext_clk, 16'h1);
    wr(6'h02, 16'hffff, 8'h00);
    rc(6'h02, 16'h0000);
    rc(6'h05, 16'h0000);
    // Converter-side enable is outside this block
    wr(`AFE_ADDR_CTRL_ONE, 16'h4000, 8'h00);
    crc_on = 1'b1;
    check("status", stat, 16'h0036);
    wr(`AFE_ADDR_CTRL_TWO, 16'h0008, 8'h00);
    rc(`AFE_ADDR_CTRL_TWO, 16'h0008);
    wr(`AFE_ADDR_CTRL_TWO, 16'h0004, 8'h01);
    rc(`AFE_ADDR_CTRL_TWO, 16'h0008);
    check("flag", flag, 16'h1);
    @(posedge mclk) checksum_error_clear <= 1'b1;
    @(posedge mclk) checksum_error_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    check("flag", flag, 16'h0);
    wr(`AFE_ADDR_CTRL_ONE, 16'h0000, 8'h00);
    crc_on = 1'b0;
    rc(`AFE_ADDR_CTRL_ONE, 16'h0000);
    complete_run;
  end
endmodule
